//--- hw/sdmr_pkg.sv
// constants and decode functions for the mode word one/two register bank
package sdmr_pkg;
  // ****************************************************
  // selector values and field positions
  // ****************************************************
  localparam logic [2:0] SDMR_SEL_WORD_ONE = 3'h1;
  localparam logic [2:0] SDMR_SEL_WORD_TWO = 3'h2;
  localparam logic [2:0] SDMR_SEL_REG_CTRL = 3'h7;
  localparam int SDMR_ADDR_W = 18;
  localparam int SDMR_CMD_W = 24;
  localparam int SDMR_SYNC_STAGES = 3;
  localparam int SDMR_POS_DLL = 0;
  localparam int SDMR_POS_DRV_LO = 1;
  localparam int SDMR_POS_AL_LO = 3;
  localparam int SDMR_POS_WLVL = 7;
  localparam int SDMR_POS_NOM_LO = 8;
  localparam int SDMR_POS_QOFF = 12;
  localparam int SDMR_POS_CWL_LO = 3;
  localparam int SDMR_POS_LPR_LO = 6;
  localparam int SDMR_POS_WRT_LO = 9;
  localparam int SDMR_POS_CRC = 12;
  localparam logic [17:0] SDMR_WORD_TWO_RSV_MASK = 18'h22107;
  // ****************************************************
  // values after reset and decoded values
  // ****************************************************
  localparam logic SDMR_RST_QOFF = 1'b0;
  localparam logic SDMR_RST_DLL = 1'b0;
  localparam logic SDMR_RST_WLVL = 1'b0;
  localparam logic SDMR_RST_CRC = 1'b0;
  localparam logic [1:0] SDMR_RST_AL = 2'h0;
  localparam logic [2:0] SDMR_RST_NOM = 3'h0;
  localparam logic [5:0] SDMR_RST_DRV = 6'h22;
  localparam logic [1:0] SDMR_RST_WRT = 2'h0;
  localparam logic [1:0] SDMR_RST_LPR = 2'h0;
  localparam logic [4:0] SDMR_RST_CWL = 5'h09;
  localparam logic SDMR_RST_HIZ = 1'b0;
  localparam logic SDMR_RST_RSV = 1'b0;
  localparam logic SDMR_RST_OE = 1'b0;
  localparam logic [5:0] SDMR_RST_ALAT = 6'h00;
  localparam logic [5:0] SDMR_DRV_OHM_34 = 6'h22;
  localparam logic [5:0] SDMR_DRV_OHM_48 = 6'h30;

  // low-power refresh range modes
  typedef enum logic [1:0] {
    SDMR_LPR_NORMAL = 2'h0,
    SDMR_LPR_REDUCED = 2'h1,
    SDMR_LPR_EXTENDED = 2'h2,
    SDMR_LPR_AUTO = 2'h3
  } sdmr_lpr_t;

  // nominal termination code to divisor of the reference resistor unit, 0 = off
  function automatic logic [2:0] sdmr_nom_div(input logic [2:0] code);
    case (code)
      3'h1: sdmr_nom_div = 3'h4;
      3'h2: sdmr_nom_div = 3'h2;
      3'h3: sdmr_nom_div = 3'h6;
      3'h4: sdmr_nom_div = 3'h1;
      3'h5: sdmr_nom_div = 3'h5;
      3'h6: sdmr_nom_div = 3'h3;
      3'h7: sdmr_nom_div = 3'h7;
      default: sdmr_nom_div = 3'h0;
    endcase
  endfunction

  // write latency code to clock cycles
  function automatic logic [4:0] sdmr_cwl(input logic [2:0] code);
    case (code)
      3'h0: sdmr_cwl = 5'h09;
      3'h1: sdmr_cwl = 5'h0a;
      3'h2: sdmr_cwl = 5'h0b;
      3'h3: sdmr_cwl = 5'h0c;
      3'h4: sdmr_cwl = 5'h0e;
      3'h5: sdmr_cwl = 5'h10;
      3'h6: sdmr_cwl = 5'h12;
      default: sdmr_cwl = 5'h14;
    endcase
  endfunction
endpackage

//--- hw/sdmr_field_decode.sv
// combinational decode of the address bits of one mode-register-set command
`timescale 1ns/1ps
module sdmr_field_decode import sdmr_pkg::*; (
  input wire logic [17:0] i_addr,
  output logic [2:0] o_nom_div,
  output logic [5:0] o_drv_ohm,
  output logic o_drv_rsv,
  output logic [1:0] o_al_code,
  output logic o_al_rsv,
  output logic [1:0] o_wrt_div,
  output logic o_wrt_hiz,
  output logic o_wrt_rsv,
  output logic [4:0] o_cwl
);
  logic [1:0] drv_code;
  logic [2:0] wrt_code;

  always_comb begin
    drv_code = i_addr[SDMR_POS_DRV_LO +: 2];
    wrt_code = i_addr[SDMR_POS_WRT_LO +: 3];
    o_nom_div = sdmr_nom_div(i_addr[SDMR_POS_NOM_LO +: 3]);
    o_drv_ohm = (drv_code == 2'h1) ? SDMR_DRV_OHM_48 : SDMR_DRV_OHM_34;
    o_drv_rsv = drv_code[1];
    o_al_code = i_addr[SDMR_POS_AL_LO +: 2];
    o_al_rsv = (o_al_code == 2'h3);
    o_wrt_hiz = (wrt_code == 3'h3);
    o_wrt_rsv = (wrt_code > 3'h4);
    case (wrt_code)
      3'h1: o_wrt_div = 2'h2;
      3'h2: o_wrt_div = 2'h1;
      3'h4: o_wrt_div = 2'h3;
      default: o_wrt_div = 2'h0;
    endcase
    o_cwl = sdmr_cwl(i_addr[SDMR_POS_CWL_LO +: 3]);
  end
endmodule // sdmr_field_decode

//--- hw/sdmr_bank.sv
// mode word one and two register bank, fed by mode-register-set commands
// Functional notes
// - bank-group bit0 and bank bits select register
// - selector all ones: command ignored entirely
// - output-off disables data and both strobes
// - address bit0: 1 enables, 0 disables loop
// - additive latency zero, CL-1, CL-2, reserved
// - nominal termination divisor per code table
// - drive strength 34 or 48 ohm
// - bits 7:6 select low-power refresh mode
// - word two bits 5:3 hold write latency
// - latency code maps nine through twenty cycles
`timescale 1ns/1ps
module sdmr_bank import sdmr_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_cmd_clk,
  input wire logic i_mrs_cmd,
  input wire logic [1:0] i_bg,
  input wire logic [1:0] i_ba,
  input wire logic [17:0] i_addr,
  input wire logic [5:0] i_cas_latency,
  input wire logic i_dq_oe_req,
  input wire logic i_dqs_oe_req,
  output logic o_dq_oe,
  output logic o_dqs_t_oe,
  output logic o_dqs_c_oe,
  output logic o_output_off,
  output logic o_dll_enable,
  output logic o_write_level_enable,
  output logic [1:0] o_additive_latency_code,
  output logic [5:0] o_additive_latency,
  output logic [2:0] o_nominal_termination_sel,
  output logic [5:0] o_output_drive_strength,
  output logic o_write_crc_enable,
  output logic [1:0] o_write_termination_sel,
  output logic o_write_termination_hiz,
  output logic [1:0] o_low_power_refresh_range,
  output logic [4:0] o_write_latency_code,
  output logic o_reserved_code_seen
);
  // ****************************************************
  // pin synchroniser and command clock edge detect
  // ****************************************************
  logic [SDMR_CMD_W-1:0] pins;
  logic [SDMR_CMD_W-1:0] s1_q, s2_q, s3_q;
  logic [SDMR_CMD_W-1:0] s1_d, s2_d, s3_d;
  logic clk_lvl_q, clk_lvl_d;
  logic take;
  logic [2:0] sel;
  logic [17:0] cap_addr;

  always_comb begin
    pins = {i_cmd_clk, i_mrs_cmd, i_bg, i_ba, i_addr};
    s1_d = pins;
    s2_d = s1_q;
    s3_d = s2_q;
    clk_lvl_d = clk_lvl_q;
    if (s2_q[23] == s3_q[23]) begin
      clk_lvl_d = s3_q[23];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      clk_lvl_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      clk_lvl_q <= clk_lvl_d;
    end
  end

  // command sampled on a rising command clock edge
  assign take = clk_lvl_d & ~clk_lvl_q & s3_q[22];
  assign sel = {s3_q[20], s3_q[19:18]};
  assign cap_addr = s3_q[17:0];

  // ****************************************************
  // field decode of the captured address
  // ****************************************************
  logic [2:0] dec_nom;
  logic [5:0] dec_drv;
  logic dec_drv_rsv, dec_al_rsv, dec_wrt_hiz, dec_wrt_rsv;
  logic [1:0] dec_al, dec_wrt;
  logic [4:0] dec_cwl;

  sdmr_field_decode u_dec (
    .i_addr(cap_addr),
    .o_nom_div(dec_nom),
    .o_drv_ohm(dec_drv),
    .o_drv_rsv(dec_drv_rsv),
    .o_al_code(dec_al),
    .o_al_rsv(dec_al_rsv),
    .o_wrt_div(dec_wrt),
    .o_wrt_hiz(dec_wrt_hiz),
    .o_wrt_rsv(dec_wrt_rsv),
    .o_cwl(dec_cwl)
  );

  // ****************************************************
  // mode word state
  // ****************************************************
  logic wr_one, wr_two;
  logic qoff_q, qoff_d, dll_q, dll_d, wlvl_q, wlvl_d, crc_q, crc_d, hiz_q, hiz_d, rsv_q, rsv_d;
  logic [1:0] al_q, al_d, wrt_q, wrt_d, lpr_q, lpr_d;
  logic [2:0] nom_q, nom_d;
  logic [5:0] drv_q, drv_d, alat_q, alat_d;
  logic [4:0] cwl_q, cwl_d;
  logic dq_oe_q, dq_oe_d, dqs_oe_q, dqs_oe_d;

  assign wr_one = take && (sel == SDMR_SEL_WORD_ONE);
  assign wr_two = take && (sel == SDMR_SEL_WORD_TWO);

  always_comb begin
    qoff_d = qoff_q;
    dll_d = dll_q;
    wlvl_d = wlvl_q;
    al_d = al_q;
    nom_d = nom_q;
    drv_d = drv_q;
    crc_d = crc_q;
    wrt_d = wrt_q;
    hiz_d = hiz_q;
    lpr_d = lpr_q;
    cwl_d = cwl_q;
    rsv_d = rsv_q;
    // fields change only on a write to their own word
    if (wr_one) begin
      qoff_d = cap_addr[SDMR_POS_QOFF];
      dll_d = cap_addr[SDMR_POS_DLL];
      wlvl_d = cap_addr[SDMR_POS_WLVL];
      al_d = dec_al;
      nom_d = dec_nom;
      drv_d = dec_drv;
      rsv_d = rsv_q | dec_al_rsv | dec_drv_rsv | s3_q[21];
    end
    if (wr_two) begin
      crc_d = cap_addr[SDMR_POS_CRC];
      wrt_d = dec_wrt;
      hiz_d = dec_wrt_hiz;
      lpr_d = cap_addr[SDMR_POS_LPR_LO +: 2];
      cwl_d = dec_cwl;
      rsv_d = rsv_q | dec_wrt_rsv | s3_q[21] | (|(cap_addr & SDMR_WORD_TWO_RSV_MASK));
    end
    case (al_q)
      2'h1: alat_d = i_cas_latency - 6'h01;
      2'h2: alat_d = i_cas_latency - 6'h02;
      default: alat_d = 6'h00;
    endcase
    dq_oe_d = i_dq_oe_req & ~qoff_q;
    dqs_oe_d = i_dqs_oe_req & ~qoff_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      qoff_q <= SDMR_RST_QOFF;
      dll_q <= SDMR_RST_DLL;
      wlvl_q <= SDMR_RST_WLVL;
      al_q <= SDMR_RST_AL;
      nom_q <= SDMR_RST_NOM;
      drv_q <= SDMR_RST_DRV;
      crc_q <= SDMR_RST_CRC;
      wrt_q <= SDMR_RST_WRT;
      hiz_q <= SDMR_RST_HIZ;
      lpr_q <= SDMR_RST_LPR;
      cwl_q <= SDMR_RST_CWL;
      rsv_q <= SDMR_RST_RSV;
      alat_q <= SDMR_RST_ALAT;
      dq_oe_q <= SDMR_RST_OE;
      dqs_oe_q <= SDMR_RST_OE;
    end else begin
      qoff_q <= qoff_d;
      dll_q <= dll_d;
      wlvl_q <= wlvl_d;
      al_q <= al_d;
      nom_q <= nom_d;
      drv_q <= drv_d;
      crc_q <= crc_d;
      wrt_q <= wrt_d;
      hiz_q <= hiz_d;
      lpr_q <= lpr_d;
      cwl_q <= cwl_d;
      rsv_q <= rsv_d;
      alat_q <= alat_d;
      dq_oe_q <= dq_oe_d;
      dqs_oe_q <= dqs_oe_d;
    end
  end

  assign o_dq_oe = dq_oe_q;
  assign o_dqs_t_oe = dqs_oe_q;
  assign o_dqs_c_oe = dqs_oe_q;
  assign o_output_off = qoff_q;
  assign o_dll_enable = dll_q;
  assign o_write_level_enable = wlvl_q;
  assign o_additive_latency_code = al_q;
  assign o_additive_latency = alat_q;
  assign o_nominal_termination_sel = nom_q;
  assign o_output_drive_strength = drv_q;
  assign o_write_crc_enable = crc_q;
  assign o_write_termination_sel = wrt_q;
  assign o_write_termination_hiz = hiz_q;
  assign o_low_power_refresh_range = lpr_q;
  assign o_write_latency_code = cwl_q;
  assign o_reserved_code_seen = rsv_q;

  // ****************************************************
  // assertions and covers
  // ****************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_ctrl_word_ignored: assert property (take && sel == SDMR_SEL_REG_CTRL |=>
    $stable(qoff_q) && $stable(nom_q) && $stable(cwl_q) && $stable(crc_q) && $stable(lpr_q))
    else $error("register control word select changed mode state");
  a_word_one_hold: assert property (!wr_one |=> $stable(nom_q) && $stable(drv_q) && $stable(dll_q))
    else $error("word one changed without a write");
  a_word_two_hold: assert property (!wr_two |=> $stable(wrt_q) && $stable(cwl_q) && $stable(crc_q))
    else $error("word two changed without a write");
  a_output_off_gate: assert property (qoff_q && $past(qoff_q) |-> !o_dq_oe && !o_dqs_t_oe && !o_dqs_c_oe)
    else $error("outputs driven while output off");
  a_dll_polarity: assert property (wr_one |=> dll_q == $past(cap_addr[0]))
    else $error("loop enable polarity wrong");
  // latency output trails the cas latency input by one cycle
  a_add_latency: assert property (al_q == 2'h2 |=>
    alat_q == $past(i_cas_latency) - 6'h02)
    else $error("additive latency not CL-2");
  a_nom_term: assert property (wr_one && cap_addr[10:8] == 3'h1 |=> nom_q == 3'h4)
    else $error("nominal termination 001 not divisor 4");
  a_drive_str: assert property (wr_one && cap_addr[2:1] == 2'h1 |=> drv_q == 6'h30)
    else $error("drive strength 01 not 48 ohm");
  a_write_crc: assert property (wr_two |=> crc_q == $past(cap_addr[12]))
    else $error("write crc not loaded");
  a_write_term: assert property (wr_two && cap_addr[11:9] == 3'h3 |=> hiz_q && wrt_q == 2'h0)
    else $error("write termination 011 not high impedance");
  a_refresh_range: assert property (wr_two |=> lpr_q == $past(cap_addr[7:6]))
    else $error("refresh range not loaded");
  a_write_latency: assert property (wr_two && cap_addr[5:3] == 3'h4 |=> cwl_q == 5'h0e)
    else $error("write latency 100 not fourteen");
  a_reserved_flag: assert property (wr_two && (|(cap_addr & SDMR_WORD_TWO_RSV_MASK)) |=> rsv_q)
    else $error("reserved bit not flagged");

  c_word_one: cover property (wr_one);
  c_word_two: cover property (wr_two);
  c_ctrl_word: cover property (take && sel == SDMR_SEL_REG_CTRL);
  c_output_off: cover property (qoff_q && i_dq_oe_req);
endmodule // sdmr_bank

//--- tb/sdmr_ctrl_model.sv
// controller-side model that issues mode-register-set commands on the command pins
`timescale 1ns/1ps
module sdmr_ctrl_model (
  input wire logic i_ref_clk,
  output logic o_cmd_clk,
  output logic o_mrs_cmd,
  output logic [1:0] o_bg,
  output logic [1:0] o_ba,
  output logic [17:0] o_addr
);
  // ****************************************************
  // idle pins
  // ****************************************************
  initial begin
    o_cmd_clk = 1'b0;
    o_mrs_cmd = 1'b0;
    o_bg = 2'h0;
    o_ba = 2'h0;
    o_addr = 18'h00000;
  end

  // ****************************************************
  // one command: pins stand four cycles either side of the clock edge
  // ****************************************************
  task automatic send(input logic [2:0] sel, input logic bg1, input logic m, input logic [17:0] ad);
    @(posedge i_ref_clk);
    #1;
    o_mrs_cmd = m;
    o_bg = {bg1, sel[2]};
    o_ba = sel[1:0];
    o_addr = ad;
    repeat (4) @(posedge i_ref_clk);
    #1;
    o_cmd_clk = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    #1;
    o_cmd_clk = 1'b0;
    // released bank-group, bank and address pins flip, command pin drops, so a stale value is never taken for a held one
    o_mrs_cmd = 1'b0;
    o_bg = ~o_bg;
    o_ba = ~o_ba;
    o_addr = ~o_addr;
  endtask
endmodule // sdmr_ctrl_model

//--- tb/test_sdmr_bank.sv
// self-checking bench for the mode word one/two register bank
`timescale 1ns/1ps
module test_sdmr_bank;
  import sdmr_pkg::*;
  logic i_ref_clk, i_reset, i_cmd_clk, i_mrs_cmd, i_dq_oe_req, i_dqs_oe_req;
  logic [1:0] i_bg, i_ba, o_additive_latency_code, o_write_termination_sel, o_low_power_refresh_range;
  logic [17:0] i_addr, a;
  logic [5:0] i_cas_latency, o_additive_latency, o_output_drive_strength;
  logic o_dq_oe, o_dqs_t_oe, o_dqs_c_oe, o_output_off, o_dll_enable, o_write_level_enable;
  logic o_write_crc_enable, o_write_termination_hiz, o_reserved_code_seen;
  logic [2:0] o_nominal_termination_sel;
  logic [4:0] o_write_latency_code;
  int seed = 37;
  int mismatches = 0;
  int checked = 0;
  int w1, w2, flag, cl;
  int nom_tab[8] = '{0, 4, 2, 6, 1, 5, 3, 7};
  int wrt_tab[8] = '{0, 2, 1, 0, 3, 0, 0, 0};
  int cwl_tab[8] = '{9, 10, 11, 12, 14, 16, 18, 20};

  sdmr_ctrl_model sdmr_ctrl_model_i (.i_ref_clk(i_ref_clk), .o_cmd_clk(i_cmd_clk), .o_mrs_cmd(i_mrs_cmd),
    .o_bg(i_bg), .o_ba(i_ba), .o_addr(i_addr));
  sdmr_bank sdmr_bank_i (.i_ref_clk, .i_reset, .i_cmd_clk, .i_mrs_cmd, .i_bg, .i_ba, .i_addr, .i_cas_latency,
    .i_dq_oe_req, .i_dqs_oe_req, .o_dq_oe, .o_dqs_t_oe, .o_dqs_c_oe, .o_output_off, .o_dll_enable,
    .o_write_level_enable, .o_additive_latency_code, .o_additive_latency, .o_nominal_termination_sel,
    .o_output_drive_strength, .o_write_crc_enable, .o_write_termination_sel, .o_write_termination_hiz,
    .o_low_power_refresh_range, .o_write_latency_code, .o_reserved_code_seen);

  // ****************************************************
  // clock, watchdog and verdict
  // ****************************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    #100000;
    mismatches++;
    summarize();
  end

  task automatic summarize();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************
  // comparisons against the integer model
  // ****************************************************
  task automatic chk_field(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_oe(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    int alc;
    int wc;
    alc = (w1 >> 3) & 3;
    wc = (w2 >> 9) & 7;
    chk_field(8'(o_output_off), 8'((w1 >> 12) & 1));
    chk_field(8'(o_dll_enable), 8'(w1 & 1));
    chk_field(8'(o_write_level_enable), 8'((w1 >> 7) & 1));
    chk_field(8'(o_additive_latency_code), 8'(alc));
    chk_field(8'(o_additive_latency), 8'(alc == 1 ? cl - 1 : (alc == 2 ? cl - 2 : 0)));
    chk_field(8'(o_nominal_termination_sel), 8'(nom_tab[(w1 >> 8) & 7]));
    chk_field(8'(o_output_drive_strength), ((w1 >> 1) & 3) == 1 ? 8'h30 : 8'h22);
    chk_field(8'(o_write_crc_enable), 8'((w2 >> 12) & 1));
    chk_field(8'(o_write_termination_sel), 8'(wrt_tab[wc]));
    chk_field(8'(o_write_termination_hiz), 8'(wc == 3));
    chk_field(8'(o_low_power_refresh_range), 8'((w2 >> 6) & 3));
    chk_field(8'(o_write_latency_code), 8'(cwl_tab[(w2 >> 3) & 7]));
    chk_field(8'(o_reserved_code_seen), 8'(flag));
    chk_oe(o_dq_oe, i_dq_oe_req & ~w1[12]);
    chk_oe(o_dqs_t_oe, i_dqs_oe_req & ~w1[12]);
    chk_oe(o_dqs_c_oe, i_dqs_oe_req & ~w1[12]);
  endtask

  // ****************************************************
  // stimulus helpers
  // ****************************************************
  // clean commands keep reserved bits low and avoid reserved codes
  function automatic logic [17:0] clean(input logic [17:0] v);
    clean = v & ~SDMR_WORD_TWO_RSV_MASK & ~18'h00810;
  endfunction

  task automatic do_reset(input int n);
    i_reset = 1'b1;
    repeat (n) @(posedge i_ref_clk);
    #1;
    i_reset = 1'b0;
    w1 = 0;
    w2 = 0;
    flag = 0;
    repeat (5) @(posedge i_ref_clk);
    #1;
    check_all();
  endtask

  task automatic cmd(input logic [2:0] sel, input logic bg1, input logic m, input logic [17:0] ad);
    @(posedge i_ref_clk);
    #1;
    i_cas_latency = 6'(9 + ($random(seed) & 15));
    cl = i_cas_latency;
    i_dq_oe_req = 1'($random(seed));
    i_dqs_oe_req = 1'($random(seed));
    sdmr_ctrl_model_i.send(sel, bg1, m, ad);
    if (m && sel == SDMR_SEL_WORD_ONE) begin
      w1 = ad;
      flag = flag | bg1 | (((ad >> 1) & 3) >= 2) | (((ad >> 3) & 3) == 3);
    end
    if (m && sel == SDMR_SEL_WORD_TWO) begin
      w2 = ad;
      flag = flag | bg1 | ((ad & SDMR_WORD_TWO_RSV_MASK) != 0) | (((ad >> 9) & 7) >= 5);
    end
    repeat (4) @(posedge i_ref_clk);
    #1;
    check_all();
  endtask

  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    i_cas_latency = 6'h09;
    i_dq_oe_req = 1'b0;
    i_dqs_oe_req = 1'b0;
    cl = 9;
    do_reset(16);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      a = clean(18'($random(seed)));
      a[10:8] = 3'(i);
      a[2:1] = 2'(i & 1);
      a[4:3] = 2'(i % 3);
      a[0] = i[1];
      cmd(SDMR_SEL_WORD_ONE, 1'b0, 1'b1, a);
      a = clean(18'($random(seed)));
      a[11:9] = 3'(i % 5);
      a[5:3] = 3'(i);
      a[7:6] = 2'(i & 3);
      a[12] = i[0];
      cmd(SDMR_SEL_WORD_TWO, 1'b0, 1'b1, a);
    end
    $display("test code tables done");
    for (int i = 0; i < 24; i++) begin
      cmd(3'($random(seed)), 1'b0, 1'($random(seed)), clean(18'($random(seed))));
    end
    cmd(SDMR_SEL_REG_CTRL, 1'b1, 1'b1, 18'h3ffff);
    $display("test selector and hold done");
    cmd(SDMR_SEL_WORD_ONE, 1'b0, 1'b1, 18'h00004);
    do_reset(2);
    cmd(SDMR_SEL_WORD_TWO, 1'b0, 1'b1, 18'h02000);
    do_reset(2);
    cmd(SDMR_SEL_WORD_TWO, 1'b0, 1'b1, 18'h00a00);
    do_reset(2);
    cmd(SDMR_SEL_WORD_TWO, 1'b1, 1'b1, 18'h00000);
    $display("test reserved codes done");
    summarize();
  end
endmodule // test_sdmr_bank
